// ==== verilog/instruction_format_decoder.sv ====
// apb-mapped operand decoder for 16-bit core instruction words
// assumes an apb3 master on pclk; no wait on other clocks
//
// Function
// RULE1 - apply table pointer mode on table ops
// RULE2 - relative offsets signed, call/jump targets absolute
// RULE3 - fast bit saves or restores shadow copies
// RULE4 - 21-bit table pointer, 8-bit table latch
// RULE5 - don't-care bits never affect decoding
// RULE6 - 7-bit source and destination index offsets
// RULE7 - destination bit picks accumulator or file
// RULE8 - 8-bit file address; access bit picks bank
// RULE9 - two-word move, 12-bit source and destination
// RULE10 - 3-bit bit number for bit ops
// RULE11 - 8-bit literal from low instruction bits
// RULE12 - two-word jump/call forms 20-bit target
// RULE13 - 11-bit always branch, 8-bit conditional branch
// RULE14 - product split into high and low bytes
// RULE15 - lone second word runs as no-operation
// RULE16 - cycle is four oscillator periods
// RULE17 - true test or pc change adds cycle
// RULE18 - classify format before extracting fields
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "ifd_defines.svh"
module instruction_format_decoder (
  input  wire logic              pclk,    // bus clock
  input  wire logic              presetn, // async reset, low
  input  wire logic              ce,      // clock enable
  input  wire logic              psel,    // apb select
  input  wire logic              penable, // apb access phase
  input  wire logic              pwrite,  // apb write
  input  wire logic [7:0]        paddr,   // apb byte address
  input  wire ifd_pkg::apb_data_t pwdata, // apb write data
  output      ifd_pkg::apb_data_t prdata, // apb read data
  output      logic              pready,  // apb ready
  output      logic              pslverr  // apb error
);
  import ifd_pkg::*;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    apb_data_t   prdata;
    seq_t        seq;
    logic [15:0] first;
    logic [15:0] last;
    fields_t     fld;
    logic [2:0]  cyc;
    logic [20:0] table_pointer;
    logic [20:0] tbladr;
    logic [7:0]  table_latch_byte;
    logic [7:0]  acc;
    logic [7:0]  bank;
    logic [7:0]  fopnd;
    logic [15:0] prod;
    logic [7:0]  sh_acc;
    logic [7:0]  sh_bank;
    logic        cond;
  } state_t;

  state_t      r;
  state_t      nxt;
  fld_if       io ();
  logic        access;
  logic        done;
  logic        wr;
  logic        known;
  logic        exec;
  logic [7:0]  addr;
  logic [7:0]  opnd;
  logic [8:0]  alu_out;
  logic [11:0] eff;
  apb_data_t   rd;

  // one step of the table pointer in the given mode
  function automatic logic [20:0] tstep(input logic [20:0] p,
                                        input tmode_t m);
    case (m)
      TM_POST_INC: tstep = p + 21'h000001;
      TM_PRE_INC:  tstep = p + 21'h000001;
      TM_POST_DEC: tstep = p - 21'h000001;
      default:     tstep = p;
    endcase
  endfunction

  // small alu for byte ops; top bit flags a result
  function automatic logic [8:0] alu(input logic [5:0] op,
                                     input logic [7:0] a,
                                     input logic [7:0] f);
    case (op)
      `ALU_ADD: alu = {1'b1, a + f};
      `ALU_AND: alu = {1'b1, a & f};
      `ALU_IOR: alu = {1'b1, a | f};
      `ALU_XOR: alu = {1'b1, a ^ f};
      `ALU_COM: alu = {1'b1, ~f};
      `ALU_MOV: alu = {1'b1, f};
      `ALU_INC: alu = {1'b1, f + 8'h01};
      `ALU_DEC: alu = {1'b1, f - 8'h01};
      default:  alu = 9'h000;
    endcase
  endfunction

  field_extract u_extract (
    .io (io)
  );

  // present the bus word; a 1111 word completes a pending pair
  assign io.word  = pwdata[15:0];
  assign io.first = r.first;
  assign io.pend  = (r.seq == ST_SECOND) &&
                    (pwdata[15:12] == `OP_CONT);

  assign access = psel && penable;
  assign done   = access && r.pready;
  assign addr   = {paddr[7:2], 2'b00};
  assign wr     = done && pwrite && (paddr[1:0] == 2'b00);
  // a lone opening word of a pair waits for its second word
  assign exec   = wr && (addr == `R_INSTR) &&
                  (io.pend || !io.f.two_word);
  assign opnd   = io.f.mul_lit ? io.f.lit : r.fopnd;
  assign alu_out = alu(io.f.op6, r.acc, r.fopnd);
  // bank from select reg or forced access bank [RULE8]
  assign eff    = r.fld.a ? {r.bank[3:0], r.fld.faddr}
                          : {`ACCESS_BANK, r.fld.faddr};

  // read mux; unmapped offsets answer with an error
  always_comb begin
    rd    = '0;
    known = (paddr[1:0] == 2'b00);
    case (addr)
      `R_INSTR:  rd = {16'h0000, r.last};
      `R_FORMAT: rd = {9'h000, r.fld.pc_chg, r.fld.two_word,
                       5'(r.cyc * `OSC_PER_ICYC), // [RULE16]
                       r.cyc, r.fld.rel, r.fld.fast,
                       r.fld.tmode, r.fld.bitn, r.fld.a,
                       r.fld.d, (r.seq == ST_SECOND),
                       r.fld.fmt};
      `R_OPER:   rd = {2'b00, r.fld.indexed_dest_offset,
                       r.fld.indexed_source_offset,
                       r.fld.lit, r.fld.faddr};
      `R_TARGET: rd = {r.fld.rel, 10'h000, r.fld.target};
      `R_MOVE:   rd = (r.fld.fmt == FMT_MOVE)
                      ? {8'h00, r.fld.fd, r.fld.fs}
                      : {20'h00000, eff};
      `R_TABLE_PTR: rd = {11'h000, r.table_pointer};
      `R_TBLLAT: rd = {24'h000000, r.table_latch_byte};
      `R_TBLADR: rd = {11'h000, r.tbladr};
      `R_ACC:    rd = {24'h000000, r.acc};
      `R_BANK:   rd = {24'h000000, r.bank};
      `R_FOPND:  rd = {24'h000000, r.fopnd};
      `R_PROD:   rd = {16'h0000, r.prod};
      `R_SHADOW: rd = {16'h0000, r.sh_bank, r.sh_acc};
      `R_CTRL:   rd = {31'h00000000, r.cond};
      default:   known = 1'b0;
    endcase
  end

  // next state: bus handshake, register writes, word execution
  always_comb begin
    nxt = r;
    // one wait state; answer is built while pready is low
    nxt.pready = access && !r.pready;
    if (access && !r.pready) begin
      nxt.prdata  = pwrite ? '0 : (known ? rd : '0);
      nxt.pslverr = !known;
    end else if (done) begin
      nxt.pslverr = 1'b0;
    end
    if (wr) begin
      case (addr)
        `R_TABLE_PTR: nxt.table_pointer = pwdata[20:0]; // [RULE4]
        `R_TBLLAT: nxt.table_latch_byte = pwdata[7:0];  // [RULE4]
        `R_ACC:    nxt.acc    = pwdata[7:0];
        `R_BANK:   nxt.bank   = pwdata[7:0];
        `R_FOPND:  nxt.fopnd  = pwdata[7:0];
        `R_CTRL:   nxt.cond   = pwdata[0];
        default:   nxt.cond   = r.cond;
      endcase
    end
    // instruction word written: decode, maybe wait for pair
    if (wr && (addr == `R_INSTR)) begin
      nxt.last = pwdata[15:0];
      nxt.fld  = io.f;
      if (!io.pend) begin
        nxt.first = pwdata[15:0];
      end
      // a broken pair is dropped; the new word starts afresh
      nxt.seq = (!io.pend && io.f.two_word) ? ST_SECOND
                                             : ST_FIRST;
      if (!exec) begin
        nxt.cyc = 3'h0;
      end
    end
    if (exec) begin
      // pair, pc change or true test add a cycle [RULE16] [RULE17]
      nxt.cyc = (io.pend || io.f.pc_chg ||
                 (io.f.cond_cap && r.cond)) ? 3'h2 : 3'h1;
      // table ops walk the pointer in the chosen mode [RULE1]
      if (io.f.tbl_rd || io.f.tbl_wr) begin
        nxt.table_pointer = tstep(r.table_pointer, io.f.tmode);
        nxt.tbladr = (io.f.tmode == TM_PRE_INC)
                     ? tstep(r.table_pointer, TM_PRE_INC)
                     : r.table_pointer;
      end
      // split product into high and low bytes [RULE14]
      if (io.f.mul || io.f.mul_lit) begin
        nxt.prod = r.acc * opnd;
      end
      // result to accumulator on d=0, file on d=1 [RULE7]
      if (io.f.fmt == FMT_BYTE && alu_out[8]) begin
        if (io.f.d) begin
          nxt.fopnd = alu_out[7:0];
        end else begin
          nxt.acc = alu_out[7:0];
        end
      end
      // shadows move only when the fast bit is set [RULE3]
      if (io.f.call && io.f.fast) begin
        nxt.sh_acc  = r.acc;
        nxt.sh_bank = r.bank;
      end
      if (io.f.ret && io.f.fast) begin
        nxt.acc  = r.sh_acc;
        nxt.bank = r.sh_bank;
      end
    end
  end

  // all state in one register; ce low freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (ce) begin
      r <= nxt;
    end
  end

  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;
endmodule

// ==== verilog/ifd_defines.svh ====
// register offsets, opcode patterns and reset values
// assumes a 32-bit apb slave, byte addresses, word aligned
`ifndef IFD_DEFINES_SVH
`define IFD_DEFINES_SVH
`define R_INSTR     8'h00
`define R_FORMAT    8'h04
`define R_OPER      8'h08
`define R_TARGET    8'h0C
`define R_MOVE      8'h10
`define R_TABLE_PTR 8'h14
`define R_TBLLAT    8'h18
`define R_TBLADR    8'h1C
`define R_ACC       8'h20
`define R_BANK      8'h24
`define R_FOPND     8'h28
`define R_PROD      8'h2C
`define R_SHADOW    8'h30
`define R_CTRL      8'h34
`define RST_BYTE    8'h00
`define RST_PTR     21'h000000
`define OSC_PER_ICYC 4
`define ACCESS_BANK 4'h0
`define OP_CONT     4'hF
`define OP_MOVE     4'hC
`define OP_RBRA     4'hD
`define OP_CTL      4'hE
`define PAT_TBLRD   14'h0002
`define PAT_TBLWR   14'h0003
`define PAT_RET     15'h0009
`define PAT_CALL    7'h76
`define PAT_JUMP    8'hEF
`define PAT_MULWF   7'h01
`define PAT_MULLW   8'h0D
`define PAT_LITB    4'h1
`define ALU_ADD     6'h09
`define ALU_AND     6'h05
`define ALU_IOR     6'h04
`define ALU_XOR     6'h06
`define ALU_COM     6'h07
`define ALU_MOV     6'h14
`define ALU_INC     6'h0A
`define ALU_DEC     6'h01
`endif

// ==== verilog/ifd_pkg.sv ====
// types shared by the decoder top and the field extractor
// assumes ifd_defines.svh for all numeric constants
package ifd_pkg;
  typedef logic [31:0] apb_data_t;
  typedef enum logic [2:0] {
    FMT_BYTE, FMT_BIT, FMT_LIT, FMT_CTRL, FMT_MOVE, FMT_CONT
  } fmt_t;
  // order follows the two mode bits of table ops
  typedef enum logic [1:0] {
    TM_NONE, TM_POST_INC, TM_POST_DEC, TM_PRE_INC
  } tmode_t;
  typedef enum logic {ST_FIRST, ST_SECOND} seq_t;
  typedef struct packed {
    fmt_t        fmt;
    logic [5:0]  op6;
    logic        d;
    logic        a;
    logic [2:0]  bitn;
    logic [7:0]  faddr;
    logic [7:0]  lit;
    logic [6:0]  indexed_source_offset;
    logic [6:0]  indexed_dest_offset;
    tmode_t      tmode;
    logic        fast;
    logic        rel;
    logic [20:0] target;
    logic [11:0] fs;
    logic [11:0] fd;
    logic        two_word;
    logic        pc_chg;
    logic        cond_cap;
    logic        tbl_rd;
    logic        tbl_wr;
    logic        call;
    logic        ret;
    logic        mul;
    logic        mul_lit;
  } fields_t;
endpackage

// ==== verilog/fld_if.sv ====
// carries a fetched word to the field extractor and fields back
// assumes both ends run combinationally on one clock
`timescale 1ns/10ps
interface fld_if;
  logic [15:0]      word;
  logic [15:0]      first;
  logic             pend;
  ifd_pkg::fields_t f;
  modport dec  (input word, first, pend, output f);
  modport core (output word, first, pend, input f);
endinterface

// ==== verilog/field_extract.sv ====
// combinational operand field extraction for one instruction word
// assumes first holds the opening word while pend is high
`timescale 1ns/10ps
module field_extract (
  fld_if.dec io // word in, fields out
);
  import ifd_pkg::*;
  logic [15:0] w;

  // sign extend a long or short relative offset to 21 bits
  function automatic logic [20:0] sx(input logic [10:0] v,
                                     input logic short);
    sx = short ? {{13{v[7]}}, v[7:0]} : {{10{v[10]}}, v};
  endfunction

  // classify by top bits first, then pick fields [RULE18]
  always_comb begin
    w = io.pend ? io.first : io.word;
    io.f = '0;
    io.f.op6   = w[15:10];
    io.f.d     = w[9];                          // [RULE7]
    io.f.a     = w[8];                          // [RULE8]
    io.f.faddr = w[7:0];                        // [RULE8]
    io.f.bitn  = w[11:9];                       // [RULE10]
    io.f.lit   = w[7:0];                        // [RULE11]
    io.f.indexed_source_offset = w[6:0];        // [RULE6]
    io.f.indexed_dest_offset   = io.pend ? io.word[6:0]
                                         : w[6:0]; // [RULE6]
    io.f.tmode = tmode_t'(w[1:0]);              // [RULE1]
    io.f.fast  = w[0];                          // [RULE3]
    // unused bits never enter a compare below [RULE5]
    case (w[15:12])
      4'h0: begin
        if (w[11:8] == 4'h0) begin
          io.f.fmt    = FMT_CTRL;
          io.f.tbl_rd = (w[15:2] == `PAT_TBLRD);
          io.f.tbl_wr = (w[15:2] == `PAT_TBLWR);
          io.f.ret    = (w[15:1] == `PAT_RET);
          io.f.pc_chg = io.f.ret;
        end else if (w[11] || w[11:8] == `PAT_LITB) begin
          io.f.fmt     = FMT_LIT;
          io.f.mul_lit = (w[15:8] == `PAT_MULLW);
        end else begin
          io.f.fmt = FMT_BYTE;
          io.f.mul = (w[15:9] == `PAT_MULWF);
        end
      end
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: io.f.fmt = FMT_BYTE;
      4'h7, 4'h8, 4'h9, 4'hA, 4'hB: begin
        io.f.fmt      = FMT_BIT;
        io.f.cond_cap = (w[15:13] == 3'b101);
      end
      `OP_MOVE: begin
        io.f.fmt      = FMT_MOVE;
        io.f.two_word = 1'b1;                   // [RULE9]
        io.f.fs       = w[11:0];                // [RULE9]
        io.f.fd       = io.word[11:0];          // [RULE9]
      end
      `OP_RBRA: begin
        io.f.fmt    = FMT_CTRL;
        io.f.rel    = 1'b1;
        io.f.pc_chg = 1'b1;
        io.f.target = sx(w[10:0], 1'b0);        // [RULE13] [RULE2]
      end
      `OP_CTL: begin
        io.f.fmt = FMT_CTRL;
        if (!w[11]) begin
          io.f.rel      = 1'b1;
          io.f.cond_cap = 1'b1;
          io.f.target   = sx(w[10:0], 1'b1);    // [RULE13] [RULE2]
        end else if (w[15:9] == `PAT_CALL ||
                     w[15:8] == `PAT_JUMP) begin
          io.f.call     = (w[15:9] == `PAT_CALL);
          io.f.fast     = w[8];                 // [RULE3]
          io.f.two_word = 1'b1;
          io.f.pc_chg   = 1'b1;
          // absolute target, low byte first word [RULE12] [RULE2]
          io.f.target   = {1'b0, io.word[11:0], w[7:0]};
        end
      end
      // a lone continuation word is a no-operation [RULE15]
      `OP_CONT: io.f.fmt = FMT_CONT;
      default: io.f.fmt = FMT_CTRL;
    endcase
  end
endmodule

// ==== verification/instruction_format_decoder_asserts.sv ====
// bus and field checks for the apb-mapped instruction decoder
// assumes one wait state per transfer as the decoder answers
`timescale 1ns/10ps
`include "ifd_defines.svh"
module instruction_format_decoder_asserts (
  input wire logic               pclk,    // bus clock
  input wire logic               presetn, // reset, low
  input wire logic               ce,      // clock enable
  input wire logic               psel,    // select
  input wire logic               penable, // access phase
  input wire logic               pwrite,  // direction
  input wire logic [7:0]         paddr,   // byte address
  input wire ifd_pkg::apb_data_t pwdata,  // write data
  input wire ifd_pkg::apb_data_t prdata,  // read data
  input wire logic               pready,  // ready
  input wire logic               pslverr  // error
);
  import ifd_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // the two phases of one bus transfer
  sequence setup_s;
    ce && psel && !penable;
  endsequence
  sequence acc_s;
    ce && psel && penable;
  endsequence
  // answer after exactly one wait state, then a single pulse
  one_wait_a: assert property (setup_s ##1 acc_s |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  pulse_once_a: assert property (ce && pready |=> !pready)
    else $error("ready longer than one cycle");
  err_rdy_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdy_acc_a: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  // refused addresses give an error and zero data
  bad_addr_a: assert property (setup_s ##1 (acc_s and
      (paddr[1:0] != 2'h0 || paddr > 8'h34))
      |=> pslverr && prdata == 32'h0)
    else $error("bad address not refused");
  good_addr_a: assert property (setup_s ##1 (acc_s and
      (paddr[1:0] == 2'h0 && paddr <= 8'h34)) |=> !pslverr)
    else $error("mapped address refused");
  // a read of the format word keeps its fields consistent
  osc_cnt_a: assert property (
      pready && !pwrite && paddr == `R_FORMAT |->
      prdata[20:16] == {prdata[15:13], 2'h0})
    else $error("periods not four per cycle");
  // a pending opening word is a move, or a jump or call
  pend_cyc_a: assert property (
      pready && !pwrite && paddr == `R_FORMAT && prdata[3]
      |-> prdata[15:13] == 3'h0
      && (prdata[2:0] == 3'h4 || prdata[2:0] == 3'h3))
    else $error("pending pair not a two-word class");
  fmt_range_a: assert property (
      pready && !pwrite && paddr == `R_FORMAT
      |-> prdata[2:0] <= 3'h5)
    else $error("format code out of range");
  ptr_width_a: assert property (
      pready && !pwrite && paddr == 8'h14
      |-> prdata[31:21] == 11'h0)
    else $error("pointer wider than 21 bits");
endmodule
bind instruction_format_decoder instruction_format_decoder_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ==== verification/instruction_format_decoder_tb.sv ====
// self-checking bench: apb register calls with expected values
// assumes the checker is bound in by its own file
`timescale 1ns/10ps
`include "ifd_defines.svh"
module instruction_format_decoder_tb;
  import ifd_pkg::*;
  localparam logic [7:0] A_PTR = 8'h14; // pointer
  localparam logic [7:0] A_LAT = 8'h18; // latch byte
  localparam logic [7:0] A_TAD = 8'h1C; // last table address
  logic       pclk;
  logic       presetn;
  logic       ce;
  logic       psel;
  logic       penable;
  logic       pwrite;
  logic [7:0] paddr;
  apb_data_t  pwdata;
  apb_data_t  prdata;
  logic       pready;
  logic       pslverr;
  logic       last_err;
  apb_data_t  rd;
  int         error_cnt;
  int         checked;
  always #50 pclk = ~pclk;
  instruction_format_decoder u_instruction_format_decoder (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic chk(input apb_data_t g, input apb_data_t e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one transfer; request held until ready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input apb_data_t d, output apb_data_t r);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    r = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input apb_data_t d);
    apb_data_t r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [7:0] a, input apb_data_t m,
                    input apb_data_t e);
    apb_data_t r;
    xfer(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // about 80 transfers of 4 cycles; over ten times that is a hang
  initial begin
    #400000;
    error_cnt++;
    test_done();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_cnt = 0;
    checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rc(A_PTR, 32'hFFFFFFFF, 32'h0);
    wr(A_PTR, 32'hFFFFFFFF);
    rc(A_PTR, 32'hFFFFFFFF, 32'h1FFFFF);
    wr(A_LAT, 32'h1AB);
    rc(A_LAT, 32'hFFFFFFFF, 32'hAB);
    // add with both destinations and both bank choices
    wr(`R_ACC, 32'h5);
    wr(`R_FOPND, 32'h3);
    wr(`R_BANK, 32'h3);
    wr(`R_INSTR, 32'h2512);
    rc(`R_ACC, 32'hFF, 32'h08);
    rc(`R_FORMAT, 32'h3F, 32'h20);
    rc(`R_MOVE, 32'hFFF, 32'h312);
    wr(`R_INSTR, 32'h2712);
    rc(`R_FOPND, 32'hFF, 32'h0B);
    wr(`R_INSTR, 32'h2412);
    rc(`R_ACC, 32'hFF, 32'h13);
    rc(`R_MOVE, 32'hFFF, 32'h012);
    wr(`R_INSTR, 32'h8B45);
    rc(`R_FORMAT, 32'h1C7, 32'h141);
    wr(`R_INSTR, 32'h0E7F);
    rc(`R_FORMAT, 32'h7, 32'h2);
    rc(`R_OPER, 32'hFF00, 32'h7F00);
    // two-word move; pending state first, then the pair
    wr(`R_INSTR, 32'hC123);
    rc(`R_FORMAT, 32'hE008, 32'h8);
    wr(`R_INSTR, 32'hF456);
    rc(`R_FORMAT, 32'h3FE00F, 32'h284004);
    rc(`R_MOVE, 32'hFFFFFF, 32'h456123);
    rc(`R_OPER, 32'h3FFF0000, 32'h2B230000);
    wr(`R_INSTR, 32'hEF34);
    wr(`R_INSTR, 32'hF567);
    rc(`R_TARGET, 32'h801FFFFF, 32'h56734);
    wr(`R_INSTR, 32'hD400);
    rc(`R_TARGET, 32'h801FFFFF, 32'h801FFC00);
    rc(`R_FORMAT, 32'h40E000, 32'h404000);
    // conditional branch costs a cycle only when the test is true
    wr(`R_CTRL, 32'h1);
    wr(`R_INSTR, 32'hE280);
    rc(`R_TARGET, 32'h801FFFFF, 32'h801FFF80);
    rc(`R_FORMAT, 32'hE000, 32'h4000);
    wr(`R_CTRL, 32'h0);
    wr(`R_INSTR, 32'hE280);
    rc(`R_FORMAT, 32'hE000, 32'h2000);
    wr(`R_INSTR, 32'hFABC);
    rc(`R_FORMAT, 32'h7, 32'h5);
    // all four pointer modes, each stepping on from the pointer the last one left
    wr(A_PTR, 32'h100);
    for (int i = 0; i < 4; i++) begin
      wr(`R_INSTR, 32'h8 + i);
      rc(A_PTR, 32'h1FFFFF, 32'h100 + (i & 1));
      rc(A_TAD, 32'h1FFFFF, 32'h100 + i / 2);
      rc(`R_FORMAT, 32'h600, i << 9);
    end
    wr(`R_ACC, 32'hF0);
    wr(`R_INSTR, 32'h0DF0);
    rc(`R_PROD, 32'hFFFF, 32'hE100);
    wr(`R_INSTR, 32'h0312);
    rc(`R_PROD, 32'hFFFF, 32'h0A50);
    // fast call saves, slow call and slow return leave shadows
    wr(`R_ACC, 32'h5A);
    wr(`R_BANK, 32'h0C);
    wr(`R_INSTR, 32'hED01);
    wr(`R_INSTR, 32'hF000);
    rc(`R_SHADOW, 32'hFFFF, 32'h0C5A);
    rc(`R_TARGET, 32'h801FFFFF, 32'h1);
    wr(`R_ACC, 32'h22);
    wr(`R_INSTR, 32'hEC00);
    wr(`R_INSTR, 32'hF000);
    rc(`R_SHADOW, 32'hFFFF, 32'h0C5A);
    wr(`R_INSTR, 32'h0012);
    rc(`R_ACC, 32'hFF, 32'h22);
    wr(`R_INSTR, 32'h0013);
    rc(`R_ACC, 32'hFF, 32'h5A);
    // refused accesses: unmapped read, misaligned write
    xfer(1'b0, 8'h40, 32'h0, rd);
    chk({31'h0, last_err}, 32'h1);
    xfer(1'b1, 8'h21, 32'hFF, rd);
    chk({31'h0, last_err}, 32'h1);
    rc(`R_ACC, 32'hFF, 32'h5A);
    chk({31'h0, last_err}, 32'h0);
    test_done();
  end
endmodule
